//--- rtl/srsal_monitor.sv
// Purpose: Soft reset status and access log registers of a port monitor.
// Assumes: Traffic strobes come from logic on clk; Wishbone classic.
// Notes: Registers answer one cycle after the strobe; writes land with ack.
//
// What this block does
// RULE_01: Status bits 5:4 give 00 unless exit is pending, else error and outstanding causes.
// RULE_02: A secure write arriving after soft reset entry sets the write-seen flag.
// RULE_03: A read arriving while the reset request bit is one sets the read-seen flag.
// RULE_04: Reentry and re-exit events clear both seen flags.
// RULE_05: Status bit 1 is high while at least one write is in flight.
// RULE_06: Status bit 0 is high while at least one read is in flight.
// RULE_07: Software writes zeros to status bits 31:6 and ignores their value.
// RULE_08: The read log keeps tag and node of the first read after isolation.
// RULE_09: The write log keeps tag and node of the first write after isolation.
// RULE_10: At an AXI ingress the tag is the raw ID, at an AHB ingress the master number.
// RULE_11: At an egress the tag is the one carried by the originating transaction.
// RULE_12: The node field is the node number of the originating ingress port.
// RULE_13: Only secure accesses can read the two log registers.
// RULE_14: Reentry also clears the capture state held with the log registers.
// RULE_15: The reset pin is asserted while the request value is one.
// RULE_16: A captured log entry is kept until the first arrival after a reentry or re-exit replaces it.
`timescale 1ns/1ns
module srsal_monitor
  import srsal_pkg::*;
#(
  parameter srsal_port_t PORT_KIND = SRSAL_AXI_IN,
  parameter logic [7:0] NODE_ID = 8'h00,
  parameter int ID_W = 24,
  parameter int HM_W = 8,
  parameter int CNT_W = 8,
  parameter bit PIN_ACT_LOW = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DW-1:0] wb_dat_i,
  input wire logic wb_secure_i,
  output logic [DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Soft reset control state
  input wire logic srst_req_i,
  input wire logic srst_entered_i,
  input wire logic exit_pend_i,
  input wire logic reentry_i,
  input wire logic reexit_i,
  input wire logic err_pend_i,
  output logic srst_pin_o,
  // Read traffic
  input wire logic rd_start_i,
  input wire logic rd_done_i,
  input wire logic [ID_W-1:0] rd_axi_id_i,
  input wire logic [TAG_W-1:0] rd_orig_tag_i,
  input wire logic [NODE_W-1:0] rd_orig_node_i,
  // Write traffic
  input wire logic wr_start_i,
  input wire logic wr_done_i,
  input wire logic wr_secure_i,
  input wire logic [ID_W-1:0] wr_axi_id_i,
  input wire logic [TAG_W-1:0] wr_orig_tag_i,
  input wire logic [NODE_W-1:0] wr_orig_node_i,
  // Shared AHB requester number
  input wire logic [HM_W-1:0] ahb_hmaster_i,
  // Interrupt
  output logic irq_o
);

  // ------------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------------
  if (ID_W < 1 || ID_W > TAG_W) begin : g_chk_id
    $error("srsal_monitor: ID_W must be 1 to 24");
  end
  if (HM_W < 1 || HM_W > TAG_W) begin : g_chk_hm
    $error("srsal_monitor: HM_W must be 1 to 24");
  end
  if (CNT_W < 1) begin : g_chk_cnt
    $error("srsal_monitor: CNT_W must be at least 1");
  end
  if (TAG_W + NODE_W != DW) begin : g_chk_log
    $error("srsal_monitor: log fields must fill one data word");
  end
  if (PORT_KIND != SRSAL_AXI_IN && PORT_KIND != SRSAL_AHB_IN &&
      PORT_KIND != SRSAL_EGRESS) begin : g_chk_kind
    $error("srsal_monitor: PORT_KIND must name a known port kind");
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [DW-1:0] dat;
    logic rd_seen;
    logic wr_seen;
    logic rd_cap;
    logic wr_cap;
    logic [DW-1:0] rd_log;
    logic [DW-1:0] wr_log;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic pin;
  } srsal_st_t;

  localparam srsal_st_t ST_RST = '{
    ack: 1'b0,
    dat: '0,
    rd_seen: 1'b0,
    wr_seen: 1'b0,
    rd_cap: 1'b0,
    wr_cap: 1'b0,
    rd_log: LOG_RST,
    wr_log: LOG_RST,
    irq_stat: IRQ_STAT_RST,
    irq_mask: IRQ_MASK_RST,
    irq: 1'b0,
    pin: PIN_ACT_LOW
  };

  srsal_st_t s_r;
  srsal_st_t s_nxt;

  // ------------------------------------------------------------------
  // Tag and node selection
  // ------------------------------------------------------------------
  function automatic logic [TAG_W-1:0] srsal_pick_tag(
    input logic [ID_W-1:0] id,
    input logic [HM_W-1:0] hm,
    input logic [TAG_W-1:0] orig
  );
    logic [TAG_W-1:0] tag;
    case (PORT_KIND)
      SRSAL_AXI_IN: begin
        tag = TAG_W'(id); // [RULE_10]
      end
      SRSAL_AHB_IN: begin
        tag = TAG_W'(hm); // [RULE_10]
      end
      default: begin
        tag = orig; // [RULE_11]
      end
    endcase
    return tag;
  endfunction : srsal_pick_tag

  function automatic logic [NODE_W-1:0] srsal_pick_node(
    input logic [NODE_W-1:0] orig
  );
    logic [NODE_W-1:0] node;
    if (PORT_KIND == SRSAL_EGRESS) begin
      node = orig; // [RULE_12]
    end else begin
      node = NODE_ID; // [RULE_12]
    end
    return node;
  endfunction : srsal_pick_node

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  function automatic logic srsal_wr_hit(
    input logic wr,
    input logic [ADR_W-1:0] adr,
    input logic [ADR_W-1:0] target
  );
    return wr && (adr == target);
  endfunction : srsal_wr_hit

  // ------------------------------------------------------------------
  // In-flight counters
  // ------------------------------------------------------------------
  srsal_txn_if txn [NDIR] ();
  logic [NDIR-1:0] starts;
  logic [NDIR-1:0] dones;
  logic [NDIR-1:0] busys;

  assign starts[DIR_RD] = rd_start_i;
  assign starts[DIR_WR] = wr_start_i;
  assign dones[DIR_RD] = rd_done_i;
  assign dones[DIR_WR] = wr_done_i;

  for (genvar g = 0; g < NDIR; g++) begin : g_cnt
    assign txn[g].start = starts[g];
    assign txn[g].done = dones[g];
    assign busys[g] = txn[g].busy;
    srsal_txn_count #(
      .CNT_W(CNT_W)
    ) u_cnt (
      .clk(clk),
      .rst(rst),
      .t(txn[g])
    );
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  logic acc;
  logic wr_acc;
  logic clr;
  logic rd_seen_ev;
  logic wr_seen_ev;
  logic rd_log_ev;
  logic wr_log_ev;
  logic rd_take;
  logic wr_take;
  logic [1:0] code;
  logic [DW-1:0] status_word;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_w1c;

  always_comb begin
    s_nxt = s_r;
    acc = wb_cyc_i && wb_stb_i && !s_r.ack;
    // A write lands at the edge where the master sees ack high.
    wr_acc = wb_cyc_i && wb_stb_i && s_r.ack && wb_we_i && wb_sel_i[0];
    clr = reentry_i || reexit_i;
    // Arrival counts as in flight from the cycle after its own start pulse.
    rd_seen_ev = rd_start_i && srst_req_i; // [RULE_03]
    wr_seen_ev = wr_start_i && wr_secure_i && srst_entered_i; // [RULE_02]
    rd_log_ev = rd_start_i && srst_entered_i;
    wr_log_ev = wr_start_i && srst_entered_i;
    // A clear in the same cycle rearms capture for this arrival.
    rd_take = rd_log_ev && (!s_r.rd_cap || clr); // [RULE_16]
    wr_take = wr_log_ev && (!s_r.wr_cap || clr); // [RULE_16]

    // Exit blocker code.
    code = CODE_OK; // [RULE_01]
    if (exit_pend_i) begin
      code[CODE_ERR_BIT] = err_pend_i; // [RULE_01]
      code[CODE_TXN_BIT] = |busys; // [RULE_01]
    end

    // Reserved bits read as zero; writes to them have no effect.
    status_word = '0; // [RULE_07]
    status_word[STS_RD_ACT] = busys[DIR_RD]; // [RULE_06]
    status_word[STS_WR_ACT] = busys[DIR_WR]; // [RULE_05]
    status_word[STS_RD_SEEN] = s_r.rd_seen;
    status_word[STS_WR_SEEN] = s_r.wr_seen;
    status_word[STS_CODE_HI:STS_CODE_LO] = code;

    // Seen flags: a set in the clearing cycle wins.
    if (clr) begin
      s_nxt.rd_seen = 1'b0; // [RULE_04]
      s_nxt.wr_seen = 1'b0; // [RULE_04]
    end
    if (rd_seen_ev) begin
      s_nxt.rd_seen = 1'b1; // [RULE_03]
    end
    if (wr_seen_ev) begin
      s_nxt.wr_seen = 1'b1; // [RULE_02]
    end

    // First-arrival capture, held until the capture state clears.
    if (clr) begin
      s_nxt.rd_cap = 1'b0; // [RULE_14]
      s_nxt.wr_cap = 1'b0; // [RULE_14]
    end
    if (rd_take) begin // [RULE_16]
      s_nxt.rd_cap = 1'b1;
      s_nxt.rd_log = {srsal_pick_tag(rd_axi_id_i, ahb_hmaster_i,
                                     rd_orig_tag_i),
                      srsal_pick_node(rd_orig_node_i)}; // [RULE_08]
    end
    if (wr_take) begin // [RULE_16]
      s_nxt.wr_cap = 1'b1;
      s_nxt.wr_log = {srsal_pick_tag(wr_axi_id_i, ahb_hmaster_i,
                                     wr_orig_tag_i),
                      srsal_pick_node(wr_orig_node_i)}; // [RULE_09]
    end

    // Interrupt status: write one to clear, new events win.
    irq_ev = '0;
    irq_ev[IRQ_RD_SEEN] = rd_seen_ev && !s_r.rd_seen;
    irq_ev[IRQ_WR_SEEN] = wr_seen_ev && !s_r.wr_seen;
    irq_ev[IRQ_RD_LOG] = rd_take;
    irq_ev[IRQ_WR_LOG] = wr_take;
    irq_w1c = '0;
    if (srsal_wr_hit(wr_acc, wb_adr_i, ADR_IRQ_STAT)) begin
      irq_w1c = wb_dat_i[IRQ_W-1:0];
    end
    s_nxt.irq_stat = (s_r.irq_stat & ~irq_w1c) | irq_ev;
    if (srsal_wr_hit(wr_acc, wb_adr_i, ADR_IRQ_MASK)) begin
      s_nxt.irq_mask = wb_dat_i[IRQ_W-1:0];
    end
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

    // Reset pin follows the request value.
    s_nxt.pin = srst_req_i ^ PIN_ACT_LOW; // [RULE_15]

    // Bus answer: one cycle later, read data registered with ack.
    s_nxt.ack = acc;
    s_nxt.dat = '0;
    if (acc && !wb_we_i) begin
      case (wb_adr_i)
        ADR_STATUS: begin
          s_nxt.dat = status_word;
        end
        ADR_RD_LOG: begin
          if (wb_secure_i) begin
            s_nxt.dat = s_r.rd_log; // [RULE_13]
          end
        end
        ADR_WR_LOG: begin
          if (wb_secure_i) begin
            s_nxt.dat = s_r.wr_log; // [RULE_13]
          end
        end
        ADR_IRQ_STAT: begin
          s_nxt.dat = {{(DW-IRQ_W){1'b0}}, s_r.irq_stat};
        end
        ADR_IRQ_MASK: begin
          s_nxt.dat = {{(DW-IRQ_W){1'b0}}, s_r.irq_mask};
        end
        default: begin
          s_nxt.dat = '0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;
  assign irq_o = s_r.irq;
  assign srst_pin_o = s_r.pin;

endmodule : srsal_monitor

//--- rtl/srsal_pkg.sv
// Purpose: Shared constants and types of the soft reset status block.
// Assumes: Byte addressed 32-bit register words.
// Notes: Offsets are byte addresses on the register bus.
package srsal_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_RD_LOG = 8'h04;
  localparam logic [7:0] ADR_WR_LOG = 8'h08;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h10;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int DW = 32;
  localparam int STS_RD_ACT = 0;
  localparam int STS_WR_ACT = 1;
  localparam int STS_RD_SEEN = 2;
  localparam int STS_WR_SEEN = 3;
  localparam int STS_CODE_LO = 4;
  localparam int STS_CODE_HI = 5;
  localparam int TAG_W = 24;
  localparam int NODE_W = 8;
  localparam logic [1:0] CODE_OK = 2'h0;
  localparam int CODE_ERR_BIT = 0;
  localparam int CODE_TXN_BIT = 1;

  // ------------------------------------------------------------------
  // Interrupt events
  // ------------------------------------------------------------------
  localparam int IRQ_W = 4;
  localparam int IRQ_RD_SEEN = 0;
  localparam int IRQ_WR_SEEN = 1;
  localparam int IRQ_RD_LOG = 2;
  localparam int IRQ_WR_LOG = 3;
  localparam logic [3:0] IRQ_STAT_RST = 4'h0;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // ------------------------------------------------------------------
  // Reset values and directions
  // ------------------------------------------------------------------
  localparam logic [31:0] LOG_RST = 32'h0000_0000;
  localparam int DIR_RD = 0;
  localparam int DIR_WR = 1;
  localparam int NDIR = 2;

  typedef enum logic [1:0] {
    SRSAL_AXI_IN = 2'h0,
    SRSAL_AHB_IN = 2'h1,
    SRSAL_EGRESS = 2'h3
  } srsal_port_t;

endpackage : srsal_pkg

//--- rtl/srsal_txn_if.sv
// Purpose: Carrier between the monitor and one in-flight counter.
// Assumes: All signals on the monitor clock.
// Notes: Start and done are one-cycle pulses.
`timescale 1ns/1ns
interface srsal_txn_if;
  logic start;
  logic done;
  logic busy;
  modport cnt (input start, input done, output busy);
  modport user (output start, output done, input busy);
endinterface : srsal_txn_if

//--- rtl/srsal_txn_count.sv
// Purpose: Counts transactions in flight in one direction.
// Assumes: Start and done pulses come from the same clock domain.
// Notes: The count saturates at both ends.
`timescale 1ns/1ns
module srsal_txn_count
  import srsal_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Counter carrier
  srsal_txn_if.cnt t
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic busy;
  } srsal_cnt_st_t;

  srsal_cnt_st_t s_r;
  srsal_cnt_st_t s_nxt;

  if (CNT_W < 1) begin : g_chk
    $error("srsal_txn_count: CNT_W must be at least 1");
  end

  always_comb begin
    s_nxt = s_r;
    if (t.start && !t.done && s_r.cnt != {CNT_W{1'b1}}) begin
      s_nxt.cnt = s_r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (t.done && !t.start && s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - {{(CNT_W-1){1'b0}}, 1'b1};
    end
    s_nxt.busy = (s_nxt.cnt != '0);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign t.busy = s_r.busy;

endmodule : srsal_txn_count

//--- dv/srsal_monitor_properties.sv
// Purpose: Port assertions of the soft reset status block.
// Assumes: One clock, synchronous active high reset.
// Notes: Bound to every monitor instance.
`timescale 1ns/1ns
module srsal_monitor_properties
  import srsal_pkg::*;
#(
  parameter bit PIN_ACT_LOW = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic wb_secure_i,
  input wire logic [DW-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Soft reset state and traffic
  input wire logic srst_req_i,
  input wire logic exit_pend_i,
  input wire logic err_pend_i,
  input wire logic srst_pin_o,
  input wire logic rd_start_i,
  input wire logic wr_start_i,
  input wire logic irq_o
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic ev;
  assign ev = rd_start_i || wr_start_i || (wb_cyc_i && wb_we_i);
  // ------------------------------------------------------------------
  // Bus cycle steps
  // ------------------------------------------------------------------
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_sts_ans;
    wb_ack_o && !wb_we_i && wb_adr_i == ADR_STATUS;
  endsequence
  sequence s_ns_log_ans;
    wb_ack_o && !wb_we_i && !wb_secure_i &&
      (wb_adr_i == ADR_RD_LOG || wb_adr_i == ADR_WR_LOG);
  endsequence
  AST_ACK_TAKE: assert property (s_take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_CODE: assert property (
    s_sts_ans |-> wb_dat_o[5:4] == ($past(exit_pend_i) ?
      {wb_dat_o[1] | wb_dat_o[0], $past(err_pend_i)} : 2'h0))
    else $error("exit blocker code wrong");
  AST_RSVD: assert property (s_sts_ans |-> wb_dat_o[31:6] == 26'h0)
    else $error("status upper bits not zero");
  AST_SECURE: assert property (s_ns_log_ans |-> wb_dat_o == 32'h0)
    else $error("log visible to non-secure read");
  AST_PIN: assert property (
    !$past(rst) |-> srst_pin_o == ($past(srst_req_i) ^ PIN_ACT_LOW))
    else $error("reset pin does not follow request");
  AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> $past(ev) || $past(ev, 2))
    else $error("interrupt rose without cause");
endmodule : srsal_monitor_properties
bind srsal_monitor srsal_monitor_properties #(.PIN_ACT_LOW(PIN_ACT_LOW)) props_u (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_secure_i(wb_secure_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .srst_req_i(srst_req_i),
  .exit_pend_i(exit_pend_i), .err_pend_i(err_pend_i),
  .srst_pin_o(srst_pin_o), .rd_start_i(rd_start_i),
  .wr_start_i(wr_start_i), .irq_o(irq_o));

//--- dv/srsal_traffic.sv
// Purpose: Traffic source model of the monitored interface.
// Assumes: Tasks are called from the bench, one at a time.
// Notes: Start and done are one-cycle pulses.
`timescale 1ns/1ns
module srsal_traffic
  import srsal_pkg::*;
(
  // Clock
  input wire logic clk,
  // Read side
  output logic rd_start,
  output logic rd_done,
  output logic [TAG_W-1:0] rd_id,
  // Write side
  output logic wr_start,
  output logic wr_done,
  output logic wr_sec,
  output logic [TAG_W-1:0] wr_id
);
  initial begin
    {rd_start, rd_done, wr_start, wr_done, wr_sec} = 5'h0;
    rd_id = 24'h0;
    wr_id = 24'h0;
  end
  // Qualifiers are inverted after the pulse so a stale ID never matches.
  task automatic go(input int d, input logic [TAG_W-1:0] id, input logic s);
    @(posedge clk);
    if (d == DIR_RD) begin
      rd_start <= 1'b1;
      rd_id <= id;
    end else begin
      wr_start <= 1'b1;
      wr_id <= id;
      wr_sec <= s;
    end
    @(posedge clk);
    rd_start <= 1'b0;
    wr_start <= 1'b0;
    rd_id <= ~rd_id;
    wr_id <= ~wr_id;
    wr_sec <= ~wr_sec;
  endtask : go
  task automatic fin(input int d);
    @(posedge clk);
    rd_done <= (d == DIR_RD);
    wr_done <= (d == DIR_WR);
    @(posedge clk);
    rd_done <= 1'b0;
    wr_done <= 1'b0;
  endtask : fin
endmodule : srsal_traffic

//--- dv/srsal_monitor_tb.sv
// Purpose: Self-checking bench of the soft reset status block.
// Assumes: AXI ingress, AHB ingress and egress instances share stimulus.
// Notes: Registers are reached by a classic Wishbone master task.
`timescale 1ns/1ns
module srsal_monitor_tb;
  import srsal_pkg::*;
  localparam logic [7:0] NODE = 8'h5A;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sec = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic req = 1'b0, ent = 1'b0, exitp = 1'b0, errp = 1'b0;
  logic reen = 1'b0, reex = 1'b0;
  logic [31:0] rd_o, rdat;
  logic [31:0] eg_o, hb_o, eg_d, hb_d;
  logic ack, pin, irq, rs, rdn, ws, wdn, wsec;
  logic [23:0] rid, wid;
  int err_total = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  srsal_monitor #(.NODE_ID(NODE)) dut_u (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_secure_i(sec),
    .wb_dat_o(rd_o), .wb_ack_o(ack), .srst_req_i(req),
    .srst_entered_i(ent), .exit_pend_i(exitp), .reentry_i(reen),
    .reexit_i(reex), .err_pend_i(errp), .srst_pin_o(pin),
    .rd_start_i(rs), .rd_done_i(rdn), .rd_axi_id_i(rid),
    .rd_orig_tag_i(rid), .rd_orig_node_i(rid[7:0]), .wr_start_i(ws),
    .wr_done_i(wdn), .wr_secure_i(wsec), .wr_axi_id_i(wid),
    .wr_orig_tag_i(wid), .wr_orig_node_i(wid[7:0]),
    .ahb_hmaster_i(wid[7:0]), .irq_o(irq));
  srsal_monitor #(.PORT_KIND(SRSAL_EGRESS)) eg_u (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_secure_i(sec),
    .wb_dat_o(eg_o), .wb_ack_o(), .srst_req_i(req),
    .srst_entered_i(ent), .exit_pend_i(exitp), .reentry_i(reen),
    .reexit_i(reex), .err_pend_i(errp), .srst_pin_o(),
    .rd_start_i(rs), .rd_done_i(rdn), .rd_axi_id_i(rid),
    .rd_orig_tag_i(~rid), .rd_orig_node_i(rid[15:8]), .wr_start_i(ws),
    .wr_done_i(wdn), .wr_secure_i(wsec), .wr_axi_id_i(wid),
    .wr_orig_tag_i(~wid), .wr_orig_node_i(wid[15:8]),
    .ahb_hmaster_i(wid[7:0]), .irq_o());
  srsal_monitor #(.PORT_KIND(SRSAL_AHB_IN), .NODE_ID(NODE)) hb_u (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_secure_i(sec),
    .wb_dat_o(hb_o), .wb_ack_o(), .srst_req_i(req),
    .srst_entered_i(ent), .exit_pend_i(exitp), .reentry_i(reen),
    .reexit_i(reex), .err_pend_i(errp), .srst_pin_o(),
    .rd_start_i(rs), .rd_done_i(rdn), .rd_axi_id_i(rid),
    .rd_orig_tag_i(rid), .rd_orig_node_i(rid[7:0]), .wr_start_i(ws),
    .wr_done_i(wdn), .wr_secure_i(wsec), .wr_axi_id_i(wid),
    .wr_orig_tag_i(wid), .wr_orig_node_i(wid[7:0]),
    .ahb_hmaster_i(wid[7:0]), .irq_o());
  srsal_traffic tr_u (.clk(clk), .rd_start(rs), .rd_done(rdn), .rd_id(rid),
    .wr_start(ws), .wr_done(wdn), .wr_sec(wsec), .wr_id(wid));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic s);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, sec} <= {2'h3, w, s};
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = rd_o;
    eg_d = eg_o;
    hb_d = hb_o;
    {cyc, stb} <= 2'h0;
    if (ack !== 1'b1) begin
      err_total++;
      test_done();
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic s, input logic [31:0] e);
    wb(1'b0, a, 32'h0, s);
    chk(rdat, e);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  initial begin
    tick(3);
    rst <= 1'b0;
    rd(ADR_STATUS, 1'b1, 32'h0);
    rd(ADR_RD_LOG, 1'b1, 32'h0);
    rd(8'h20, 1'b1, 32'h0);
    chk1(pin, 1'b1);
    $display("test reset done");
    tr_u.go(DIR_RD, 24'h000001, 1'b0);
    rd(ADR_STATUS, 1'b1, 32'h1);
    tr_u.go(DIR_WR, 24'h000002, 1'b1);
    rd(ADR_STATUS, 1'b1, 32'h3);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {exitp, errp} <= i[1:0];
      rd(ADR_STATUS, 1'b1, {26'h0, i[1], i[1] & i[0], 4'h3});
    end
    tr_u.fin(DIR_RD);
    tr_u.fin(DIR_WR);
    rd(ADR_STATUS, 1'b1, 32'h10);
    exitp <= 1'b0;
    $display("test in flight done");
    req <= 1'b1;
    tick(2);
    chk1(pin, 1'b0);
    tr_u.go(DIR_RD, 24'h123456, 1'b0);
    tr_u.fin(DIR_RD);
    rd(ADR_STATUS, 1'b1, 32'h4);
    rd(ADR_RD_LOG, 1'b1, 32'h0);
    ent <= 1'b1;
    tr_u.go(DIR_WR, 24'hABCDEF, 1'b0);
    tr_u.fin(DIR_WR);
    rd(ADR_STATUS, 1'b1, 32'h4);
    rd(ADR_WR_LOG, 1'b1, {24'hABCDEF, NODE});
    chk(eg_d, 32'h5432_10CD);
    chk(hb_d, 32'h0000_EF5A);
    tr_u.go(DIR_WR, 24'h13579B, 1'b1);
    tr_u.fin(DIR_WR);
    rd(ADR_STATUS, 1'b1, 32'hC);
    rd(ADR_WR_LOG, 1'b1, {24'hABCDEF, NODE});
    tr_u.go(DIR_RD, 24'h2468AC, 1'b0);
    tr_u.go(DIR_RD, 24'h111111, 1'b0);
    tr_u.fin(DIR_RD);
    tr_u.fin(DIR_RD);
    rd(ADR_RD_LOG, 1'b1, {24'h2468AC, NODE});
    chk(eg_d, 32'hDB97_5368);
    rd(ADR_RD_LOG, 1'b0, 32'h0);
    rd(ADR_WR_LOG, 1'b0, 32'h0);
    $display("test capture done");
    chk1(irq, 1'b0);
    wb(1'b1, ADR_IRQ_MASK, 32'h0000_000F, 1'b1);
    tick(2);
    chk1(irq, 1'b1);
    rd(ADR_IRQ_STAT, 1'b1, 32'hF);
    wb(1'b1, ADR_IRQ_STAT, 32'h0000_000F, 1'b1);
    tick(2);
    chk1(irq, 1'b0);
    $display("test interrupt done");
    @(posedge clk);
    reen <= 1'b1;
    @(posedge clk);
    reen <= 1'b0;
    rd(ADR_STATUS, 1'b1, 32'h0);
    tr_u.go(DIR_RD, 24'h0F0F0F, 1'b0);
    tr_u.fin(DIR_RD);
    rd(ADR_RD_LOG, 1'b1, {24'h0F0F0F, NODE});
    rd(ADR_STATUS, 1'b1, 32'h4);
    @(posedge clk);
    reex <= 1'b1;
    @(posedge clk);
    reex <= 1'b0;
    rd(ADR_STATUS, 1'b1, 32'h0);
    $display("test clear done");
    test_done();
  end
endmodule : srsal_monitor_tb
